// file: include/oss_pkg.sv
// Package of constants and types for the output status selector.
package oss_pkg;

    // Frequencies are unsigned counts of 0.1 Hz.
    localparam int unsigned FREQ_W = 13;
    typedef logic [FREQ_W-1:0] oss_freq_t;
    typedef logic [4:0]        oss_sel_t;
    typedef logic [2:0]        oss_mask_t;

    // Setting limits and reset values, in units of 0.1 Hz.
    localparam oss_freq_t FREQ_SPAN_MAX     = 13'h0fa0;
    localparam oss_freq_t LEVEL_RST         = 13'h012c;
    localparam oss_freq_t BANDWIDTH_RST     = 13'h0064;
    localparam oss_freq_t MAX_FREQ_RST      = 13'h0fa0;

    // Selection codes.
    localparam oss_sel_t SEL_FREQ_MATCH     = 5'h00;
    localparam oss_sel_t SEL_LEVEL_MATCH    = 5'h01;
    localparam oss_sel_t SEL_LEVEL_WINDOW   = 5'h02;
    localparam oss_sel_t SEL_ABOVE_LEVEL    = 5'h03;
    localparam oss_sel_t SEL_ABOVE_INV      = 5'h04;
    localparam oss_sel_t SEL_MOTOR_OL       = 5'h05;
    localparam oss_sel_t SEL_DRIVE_OL       = 5'h06;
    localparam oss_sel_t SEL_STALL          = 5'h07;
    localparam oss_sel_t SEL_OVERVOLT       = 5'h08;
    localparam oss_sel_t SEL_UNDERVOLT      = 5'h09;
    localparam oss_sel_t SEL_OVERHEAT       = 5'h0a;
    localparam oss_sel_t SEL_CMD_LOSS       = 5'h0b;
    localparam oss_sel_t SEL_RUNNING        = 5'h0c;
    localparam oss_sel_t SEL_STOPPED        = 5'h0d;
    localparam oss_sel_t SEL_CONST_RUN      = 5'h0e;
    localparam oss_sel_t SEL_SPEED_SEARCH   = 5'h0f;
    localparam oss_sel_t SEL_WAIT_RUN       = 5'h10;
    localparam oss_sel_t SEL_FAULT          = 5'h11;
    localparam oss_sel_t TRANSISTOR_SEL_RST = 5'h0c;
    localparam oss_sel_t RELAY_SEL_RST      = 5'h11;

    // Fault mask fields and reset value.
    localparam int unsigned MASK_UV_BIT      = 0;
    localparam int unsigned MASK_TRIP_BIT    = 1;
    localparam int unsigned MASK_RESTART_BIT = 2;
    localparam oss_mask_t   FAULT_MASK_RST   = 3'h2;

    // Register byte addresses.
    localparam logic [11:0] ADDR_TRANSISTOR_SEL = 12'h000;
    localparam logic [11:0] ADDR_RELAY_SEL      = 12'h004;
    localparam logic [11:0] ADDR_FAULT_MASK     = 12'h008;
    localparam logic [11:0] ADDR_DETECT_LEVEL   = 12'h00c;
    localparam logic [11:0] ADDR_DETECT_BW      = 12'h010;
    localparam logic [11:0] ADDR_MAX_FREQ       = 12'h014;
    localparam logic [11:0] ADDR_STATUS         = 12'h018;
    localparam logic [11:0] ADDR_REFUSED        = 12'h01c;

endpackage

// file: include/oss_flags_if.sv
// Interface carrying frequency-detection results between modules.
`timescale 1ns/1ps
interface oss_flags_if;
    logic freq_match_window;
    logic freq_level_match;
    logic level_window;
    logic freq_above_level;
    logic freq_above_level_inv;

    modport producer (output freq_match_window, output freq_level_match, output level_window,
                      output freq_above_level, output freq_above_level_inv);
    modport consumer (input freq_match_window, input freq_level_match, input level_window,
                      input freq_above_level, input freq_above_level_inv);
endinterface

// file: hw/oss_freq_detect.sv
// Frequency detection comparators for the output status selector.
`timescale 1ns/1ps
module oss_freq_detect
    import oss_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire oss_freq_t preset_freq,
    input  wire oss_freq_t output_freq,
    input  wire oss_freq_t run_freq,
    input  wire logic      accelerating,
    input  wire logic      decelerating,
    input  wire oss_freq_t level,
    input  wire oss_freq_t bandwidth,
    oss_flags_if.producer  flags
);

    // Compare 2*|a-b| against bandwidth so odd bandwidths lose no half step.
    function automatic logic within_half(input oss_freq_t a, input oss_freq_t b, input oss_freq_t bw);
        logic [FREQ_W:0] diff;
        diff = (a >= b) ? {1'b0, a - b} : {1'b0, b - a};
        return ({diff, 1'b0} <= {2'b00, bw});
    endfunction

    logic            match_nxt;
    logic            level_nxt;
    logic            window_nxt;
    logic            above_nxt;
    logic            above_r;
    logic [FREQ_W:0] run2;
    logic [FREQ_W:0] lvl2_minus;

    always_comb
    begin
        match_nxt  = within_half(preset_freq, output_freq, bandwidth);
        level_nxt  = (preset_freq == level) && match_nxt;
        window_nxt = within_half(level, run_freq, bandwidth);
        run2       = {run_freq, 1'b0};
        lvl2_minus = {level, 1'b0} - {1'b0, bandwidth};
        above_nxt  = above_r;
        if (accelerating)
            above_nxt = (run_freq >= level);
        else if (decelerating)
            above_nxt = ({level, 1'b0} < {1'b0, bandwidth}) || (run2 > lvl2_minus);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            above_r <= 1'b0;
        else
            above_r <= above_nxt;
    end

    assign flags.freq_match_window    = match_nxt;
    assign flags.freq_level_match     = level_nxt;
    assign flags.level_window         = window_nxt;
    assign flags.freq_above_level     = above_nxt;
    assign flags.freq_above_level_inv = ~above_nxt;

endmodule

// file: hw/oss_top.sv
// Output status selector: drives the transistor output pin and the status relay.
//
// Operation
// - Code 0: |preset-output| <= bandwidth/2.
// - Bandwidth 0..400 Hz, default 10, larger writes refused.
// - Code 1: preset equals level and code 0.
// - Level 0..400 Hz, default 30, larger writes refused.
// - Code 2: |level-run| <= bandwidth/2.
// - Code 3: accel/decel level thresholds.
// - Code 4: inverse of code 3.
// - Codes 5-7: overload, drive overload, stall.
// - Code 8: overvoltage trip.
// - Code 9: undervoltage trip.
// - Code 10: heatsink overheat.
// - Code 11: frequency command lost.
// - Code 12: run command and output voltage.
// - Codes 13, 14: stopped, constant speed.
// - Code 15: speed search active.
// - Code 16: waiting for run command.
// - Code 17: output follows fault mask.
// - Mask 2: any trip except undervoltage.
// - Mask bits: undervoltage, other trips, restart.
`timescale 1ns/1ps
module oss_top
    import oss_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire oss_freq_t   preset_freq,
    input  wire oss_freq_t   output_freq,
    input  wire oss_freq_t   run_freq,
    input  wire logic        accelerating,
    input  wire logic        decelerating,
    input  wire logic        motor_overload_warn,
    input  wire logic        drive_overload_flag,
    input  wire logic        stall_active,
    input  wire logic        overvoltage_trip,
    input  wire logic        undervoltage_trip,
    input  wire logic        heatsink_overheat_flag,
    input  wire logic        other_trip,
    input  wire logic        freq_cmd_lost,
    input  wire logic        run_command,
    input  wire logic        output_voltage_on,
    input  wire logic        drive_stopped,
    input  wire logic        constant_speed,
    input  wire logic        speed_search_active,
    input  wire logic        waiting_run_cmd,
    input  wire logic        auto_restart_enabled,
    output logic             transistor_output_pin,
    output logic             status_relay
);

    oss_sel_t  transistor_output_select_r;
    oss_sel_t  relay_output_select_r;
    oss_mask_t fault_output_mask_r;
    oss_freq_t freq_detect_level_r;
    oss_freq_t freq_detect_bandwidth_r;
    oss_freq_t max_frequency_limit_r;
    logic      refused_r;
    logic      fault_nxt;
    logic      any_trip;
    logic      wr_en;
    logic      rd_en;
    logic      addr_ok;
    oss_freq_t wfreq;

    oss_flags_if flags_if ();

    oss_freq_detect u_detect (
        .pclk         (pclk),
        .presetn      (presetn),
        .preset_freq  (preset_freq),
        .output_freq  (output_freq),
        .run_freq     (run_freq),
        .accelerating (accelerating),
        .decelerating (decelerating),
        .level        (freq_detect_level_r),
        .bandwidth    (freq_detect_bandwidth_r),
        .flags        (flags_if.producer)
    );

    // Level and bandwidth settings accept a value only up to both limits.
    function automatic logic freq_ok(input oss_freq_t v, input oss_freq_t maxf);
        return (v <= FREQ_SPAN_MAX) && (v <= maxf);
    endfunction

    // Status of one output for a selection code; unused codes read as inactive.
    function automatic logic select_status(input oss_sel_t sel, input logic [17:0] src);
        return (sel <= SEL_FAULT) ? src[sel] : 1'b0;
    endfunction

    // Zero wait state slave: every access completes in its first access cycle.
    assign pready = 1'b1;
    // Writes to unmapped offsets are dropped here rather than answered with an error.
    assign wr_en  = psel && penable && pwrite && addr_ok;
    // Read data is loaded in the setup cycle so that it stands for the whole access phase.
    assign rd_en  = psel && !penable && !pwrite;
    assign wfreq  = pwdata[FREQ_W-1:0];
    assign pslverr = 1'b0;

    always_comb
    begin
        unique case (paddr)
            ADDR_TRANSISTOR_SEL, ADDR_RELAY_SEL, ADDR_FAULT_MASK, ADDR_DETECT_LEVEL,
            ADDR_DETECT_BW, ADDR_MAX_FREQ, ADDR_STATUS, ADDR_REFUSED: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            transistor_output_select_r <= TRANSISTOR_SEL_RST;
            relay_output_select_r      <= RELAY_SEL_RST;
            fault_output_mask_r        <= FAULT_MASK_RST;
            max_frequency_limit_r      <= MAX_FREQ_RST;
        end
        else if (wr_en)
        begin
            if (paddr == ADDR_TRANSISTOR_SEL)
                transistor_output_select_r <= pwdata[4:0];
            if (paddr == ADDR_RELAY_SEL)
                relay_output_select_r <= pwdata[4:0];
            if (paddr == ADDR_FAULT_MASK)
                fault_output_mask_r <= pwdata[2:0];
            if (paddr == ADDR_MAX_FREQ && wfreq <= FREQ_SPAN_MAX)
                max_frequency_limit_r <= wfreq;
        end
    end

    // Refused level and bandwidth writes leave the old setting and raise a sticky flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            freq_detect_level_r     <= LEVEL_RST;
            freq_detect_bandwidth_r <= BANDWIDTH_RST;
            refused_r               <= 1'b0;
        end
        else if (wr_en)
        begin
            if (paddr == ADDR_DETECT_LEVEL)
            begin
                if (freq_ok(wfreq, max_frequency_limit_r))
                    freq_detect_level_r <= wfreq;
                else
                    refused_r <= 1'b1;
            end
            if (paddr == ADDR_DETECT_BW)
            begin
                if (freq_ok(wfreq, max_frequency_limit_r))
                    freq_detect_bandwidth_r <= wfreq;
                else
                    refused_r <= 1'b1;
            end
            if (paddr == ADDR_REFUSED && pwdata[0])
                refused_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
        begin
            unique case (paddr)
                ADDR_TRANSISTOR_SEL: prdata <= {27'h0, transistor_output_select_r};
                ADDR_RELAY_SEL:      prdata <= {27'h0, relay_output_select_r};
                ADDR_FAULT_MASK:     prdata <= {29'h0, fault_output_mask_r};
                ADDR_DETECT_LEVEL:   prdata <= {19'h0, freq_detect_level_r};
                ADDR_DETECT_BW:      prdata <= {19'h0, freq_detect_bandwidth_r};
                ADDR_MAX_FREQ:       prdata <= {19'h0, max_frequency_limit_r};
                ADDR_STATUS:         prdata <= {30'h0, status_relay, transistor_output_pin};
                ADDR_REFUSED:        prdata <= {31'h0, refused_r};
                default:             prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_comb
    begin
        // Undervoltage is left out, so bit 1 still fires when both kinds of trip coincide.
        any_trip = overvoltage_trip || heatsink_overheat_flag || other_trip || drive_overload_flag;
        fault_nxt = 1'b0;
        // Undervoltage trips gated by bit 0 only.
        if (fault_output_mask_r[MASK_UV_BIT] && undervoltage_trip)
            fault_nxt = 1'b1;
        if (fault_output_mask_r[MASK_TRIP_BIT] && any_trip)
            fault_nxt = 1'b1;
        if (fault_output_mask_r[MASK_RESTART_BIT] && auto_restart_enabled)
            fault_nxt = 1'b1;
    end

    logic [17:0] src;

    always_comb
    begin
        src[SEL_FREQ_MATCH]   = flags_if.freq_match_window;
        src[SEL_LEVEL_MATCH]  = flags_if.freq_level_match;
        src[SEL_LEVEL_WINDOW] = flags_if.level_window;
        src[SEL_ABOVE_LEVEL]  = flags_if.freq_above_level;
        src[SEL_ABOVE_INV]    = flags_if.freq_above_level_inv;
        src[SEL_MOTOR_OL]     = motor_overload_warn;
        src[SEL_DRIVE_OL]     = drive_overload_flag;
        src[SEL_STALL]        = stall_active;
        src[SEL_OVERVOLT]     = overvoltage_trip;
        src[SEL_UNDERVOLT]    = undervoltage_trip;
        src[SEL_OVERHEAT]     = heatsink_overheat_flag;
        src[SEL_CMD_LOSS]     = freq_cmd_lost;
        src[SEL_RUNNING]      = run_command && output_voltage_on;
        src[SEL_STOPPED]      = drive_stopped;
        src[SEL_CONST_RUN]    = constant_speed;
        src[SEL_SPEED_SEARCH] = speed_search_active;
        src[SEL_WAIT_RUN]     = waiting_run_cmd;
        src[SEL_FAULT]        = fault_nxt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            transistor_output_pin <= 1'b0;
            status_relay          <= 1'b0;
        end
        else
        begin
            transistor_output_pin <= select_status(transistor_output_select_r, src);
            status_relay          <= select_status(relay_output_select_r, src);
        end
    end

endmodule

// file: test/oss_top_assertions.sv
// Checker of output routing for the output status selector.
`timescale 1ns/1ps
module oss_top_checker
    import oss_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire oss_freq_t   preset_freq,
    input wire oss_freq_t   output_freq,
    input wire logic        drive_overload_flag,
    input wire logic        overvoltage_trip,
    input wire logic        undervoltage_trip,
    input wire logic        heatsink_overheat_flag,
    input wire logic        other_trip,
    input wire logic        freq_cmd_lost,
    input wire logic        drive_stopped,
    input wire logic        transistor_output_pin,
    input wire logic        status_relay
);
    oss_sel_t  tsel_r;
    oss_sel_t  rsel_r;
    oss_mask_t mask_r;
    logic      trip_any;
    assign trip_any = overvoltage_trip | heatsink_overheat_flag | drive_overload_flag | other_trip;
    // Shadow copies follow software writes, because the checker cannot see inside the block.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tsel_r <= TRANSISTOR_SEL_RST;
            rsel_r <= RELAY_SEL_RST;
            mask_r <= FAULT_MASK_RST;
        end
        else if (psel && penable && pwrite)
        begin
            if (paddr == ADDR_TRANSISTOR_SEL) tsel_r <= pwdata[4:0];
            if (paddr == ADDR_RELAY_SEL) rsel_r <= pwdata[4:0];
            if (paddr == ADDR_FAULT_MASK) mask_r <= pwdata[2:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_freq_match: assert property (tsel_r == SEL_FREQ_MATCH && preset_freq == output_freq
        |=> transistor_output_pin)
        else $error("window output low at equal frequencies");
    chk_above_inv: assert property (tsel_r == SEL_ABOVE_INV && rsel_r == SEL_ABOVE_LEVEL
        |=> transistor_output_pin != status_relay)
        else $error("inverted level output equals plain one");
    chk_drive_ol: assert property (rsel_r == SEL_DRIVE_OL |=> status_relay == $past(drive_overload_flag))
        else $error("relay does not follow drive overload");
    chk_undervolt_route: assert property (tsel_r == SEL_UNDERVOLT
        |=> transistor_output_pin == $past(undervoltage_trip))
        else $error("pin does not follow undervoltage trip");
    chk_cmd_loss: assert property (rsel_r == SEL_CMD_LOSS |=> status_relay == $past(freq_cmd_lost))
        else $error("relay does not follow command loss");
    chk_stopped_route: assert property (tsel_r == SEL_STOPPED |=> transistor_output_pin == $past(drive_stopped))
        else $error("pin does not follow stopped state");
    chk_bad_code: assert property (tsel_r > SEL_FAULT |=> !transistor_output_pin)
        else $error("pin high under an unused code");
    chk_fault_mask: assert property (rsel_r == SEL_FAULT && mask_r == 3'h2 |=> status_relay == $past(trip_any))
        else $error("relay does not follow non undervoltage trips");
endmodule

bind oss_top oss_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .preset_freq(preset_freq), .output_freq(output_freq),
    .drive_overload_flag(drive_overload_flag), .overvoltage_trip(overvoltage_trip),
    .undervoltage_trip(undervoltage_trip), .heatsink_overheat_flag(heatsink_overheat_flag),
    .other_trip(other_trip), .freq_cmd_lost(freq_cmd_lost), .drive_stopped(drive_stopped),
    .transistor_output_pin(transistor_output_pin), .status_relay(status_relay));

// file: test/oss_seq_model.sv
// Model of the external sequence that scans the relay contact.
`timescale 1ns/1ps
module oss_seq_model
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic status_relay,
    output int        relay_events
);
    logic relay_q;
    // The sequence scans once a cycle, so a closure shorter than a cycle is never seen.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            relay_q      <= 1'b0;
            relay_events <= 0;
        end
        else
        begin
            relay_q <= status_relay;
            if (status_relay && !relay_q) relay_events <= relay_events + 1;
        end
    end
endmodule

// file: test/tb_output_status_selector.sv
// Self-checking testbench for the output status selector.
`timescale 1ns/1ps
module tb_output_status_selector
    import oss_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    oss_freq_t   pre = 13'h0000;
    oss_freq_t   outf = 13'h0000;
    oss_freq_t   run = 13'h0000;
    logic [16:0] fl = 17'h00000;
    logic        pin;
    logic        rly;
    logic        ab = 1'b0;
    logic [31:0] rd;
    logic [16:0] f;
    int          relay_events, mismatches, samples_checked, cycles, p, n;
    int          tsel = 12, rsel = 17, mask = 2, lvl = 300, bw = 100;
    logic [11:0] ra [8] = '{ADDR_TRANSISTOR_SEL, ADDR_RELAY_SEL, ADDR_FAULT_MASK, ADDR_DETECT_LEVEL,
                            ADDR_DETECT_BW, ADDR_MAX_FREQ, ADDR_REFUSED, 12'h020};
    logic [31:0] rv [8] = '{32'hc, 32'h11, 32'h2, 32'h12c, 32'h64, 32'hfa0, 32'h0, 32'h0};
    int          wo [4] = '{350, 351, 250, 249};
    int          ar [4] = '{299, 300, 251, 250};

    always #2.5 pclk = ~pclk;

    oss_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .preset_freq(pre), .output_freq(outf), .run_freq(run), .accelerating(fl[0]), .decelerating(fl[1]),
        .motor_overload_warn(fl[2]), .drive_overload_flag(fl[3]), .stall_active(fl[4]),
        .overvoltage_trip(fl[5]), .undervoltage_trip(fl[6]), .heatsink_overheat_flag(fl[7]),
        .other_trip(fl[8]), .freq_cmd_lost(fl[9]), .run_command(fl[10]), .output_voltage_on(fl[11]),
        .drive_stopped(fl[12]), .constant_speed(fl[13]), .speed_search_active(fl[14]),
        .waiting_run_cmd(fl[15]), .auto_restart_enabled(fl[16]), .transistor_output_pin(pin),
        .status_relay(rly));
    oss_seq_model SEQ (.pclk(pclk), .presetn(presetn), .status_relay(rly), .relay_events(relay_events));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        check("slave error", {31'h0, pslverr}, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input int d);
        apb(1'b1, a, 32'(d));
        if (a == ADDR_TRANSISTOR_SEL) tsel = d;
        if (a == ADDR_RELAY_SEL) rsel = d;
        if (a == ADDR_FAULT_MASK) mask = d;
        if (a == ADDR_DETECT_LEVEL && d <= 4000) lvl = d;
        if (a == ADDR_DETECT_BW && d <= 4000) bw = d;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("register", rd, exp);
    endtask

    function automatic logic exp_out(input int s, input int m, input logic [16:0] g, input int a, input int o,
                                     input int r);
        logic c0;
        c0 = 2 * ((a > o) ? a - o : o - a) <= bw;
        case (s)
            0: return c0;
            1: return a == lvl && c0;
            2: return 2 * ((lvl > r) ? lvl - r : r - lvl) <= bw;
            3: return ab;
            4: return !ab;
            5, 6, 7, 8, 9, 10: return g[s - 3];
            11: return g[9];
            12: return g[10] & g[11];
            13, 14, 15, 16: return g[s - 1];
            17: return (m[0] & g[6]) | (m[1] & (g[5] | g[7] | g[3] | g[8])) | (m[2] & g[16]);
            default: return 1'b0;
        endcase
    endfunction

    task automatic apply(input logic [16:0] g, input int a, input int o, input int r);
        @(posedge pclk);
        fl <= g;
        pre <= 13'(a);
        outf <= 13'(o);
        run <= 13'(r);
        if (g[0]) ab = r >= lvl;
        else if (g[1]) ab = 2 * r > 2 * lvl - bw;
        @(posedge pclk);
        #1;
        check("transistor output", {31'h0, pin}, {31'h0, exp_out(tsel, mask, g, a, o, r)});
        check("relay output", {31'h0, rly}, {31'h0, exp_out(rsel, mask, g, a, o, r)});
    endtask

    initial
    begin
        n = $urandom(1);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) rdchk(ra[i], rv[i]);
        $display("test reset values done");
        for (int i = 0; i < 2; i++)
        begin
            wr(ra[3 + i], 4001);
            rdchk(ra[3 + i], rv[3 + i]);
            rdchk(ADDR_REFUSED, 32'h1);
            wr(ADDR_REFUSED, 1);
            rdchk(ADDR_REFUSED, 32'h0);
            wr(ra[3 + i], 4000);
            rdchk(ra[3 + i], 32'hfa0);
            wr(ra[3 + i], 32'(rv[3 + i]));
        end
        $display("test setting limits done");
        wr(ADDR_TRANSISTOR_SEL, 0);
        wr(ADDR_RELAY_SEL, 1);
        foreach (wo[i]) apply(17'h0, 300, wo[i], 300);
        wr(ADDR_TRANSISTOR_SEL, 4);
        wr(ADDR_RELAY_SEL, 3);
        foreach (ar[i]) apply(i < 2 ? 17'h1 : 17'h2, 300, 300, ar[i]);
        $display("test window edges done");
        for (int k = 0; k < 320; k++)
        begin
            if (k % 8 == 0)
            begin
                wr(ADDR_TRANSISTOR_SEL, k / 8 % 20);
                wr(ADDR_RELAY_SEL, (k / 8) % 2 ? 17 : k / 16 % 18);
                wr(ADDR_FAULT_MASK, k / 16 % 8);
            end
            f = 17'($urandom);
            f[1] = ~f[0];
            p = ($urandom % 3 == 0) ? lvl : 250 + $urandom % 100;
            apply(f, p, p + $urandom % 120 - 60, 240 + $urandom % 120);
        end
        $display("test random codes done");
        wr(ADDR_RELAY_SEL, 17);
        wr(ADDR_FAULT_MASK, 2);
        n = relay_events;
        for (int i = 0; i < 4; i++) apply(17'(i % 2) << 8, 300, 300, 300);
        @(posedge pclk);
        #1;
        check("relay closures", 32'(relay_events - n), 32'h2);
        rdchk(ADDR_STATUS, 32'h2);
        $display("test fault relay done");
        final_report();
    end
endmodule
